// ==== src/dcf_defines.svh ====
// constants of the single-clock flag and retransmit fifo
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH
`define DCF_DATA_W 36
`define DCF_DEPTH 1024
`define DCF_STG_DEPTH 4
`define DCF_OFFSET_DEF 10'h07F
`define DCF_RT_SETUP_NS 120
`define DCF_CLK_NS 40
`define DCF_RT_SETUP_CYC ((`DCF_RT_SETUP_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`endif

// ==== src/dcf_pkg.sv ====
// types shared by the flag and retransmit fifo
package dcf_pkg;
    // mode selects latched by the master reset strobe
    typedef struct packed {
        logic fall_through_mode;      // fall-through timing
        logic zero_lat;  // zero-latency retransmit
        logic sync_flg;  // synchronous almost flags
    } dcf_cfg_t;
    // retransmit sequencer
    typedef enum logic [1:0] {
        DCF_RT_IDLE = 2'b00,
        DCF_RT_SETUP = 2'b01
    } dcf_rt_state_t;
endpackage : dcf_pkg

// ==== src/dcf_top.sv ====
// flag, retransmit and offset logic of a deep fifo with a staging buffer
//
// Function
// - full released one cycle after freeing read
// - standard empty released two cycles after write
// - fall-through word shown three cycles after write
// - sync almost-empty released two cycles after write
// - input ready one cycle after freeing read
// - sync almost-full released one cycle after read
// - depth is power of two, plus one fall-through
// - standard retransmit ends with empty flag high
// - fall-through retransmit ends ready low, first word
// - latency select high picks normal retransmit
// - latency select low picks zero retransmit
// - zero retransmit on empty updates flag, data
// - sync almost-full follows the level on every edge
// - async almost-full set by write, freed read
// - async almost-empty set by read, freed write
// - offsets loaded and read back in parallel
// - zero retransmit loads first word same edge
`timescale 1ns/1ps
`include "dcf_defines.svh"

// ----------------------------------------------------------------
// staging buffer in front of the main memory
// ----------------------------------------------------------------
module dcf_stage_fifo #(
    parameter int WIDTH = `DCF_DATA_W,
    parameter int DEPTH = `DCF_STG_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // word storage
    logic [AW:0] wp_reg;            // write pointer, wrap bit on top
    logic [AW:0] rp_reg;            // read pointer
    logic push;
    logic pop;

    // honest flags from the pointer difference
    assign count_o = wp_reg - rp_reg;
    assign in_ready_o = (count_o != DEPTH[AW:0]);
    assign out_valid_o = (count_o != '0);
    assign out_data_o = mem[rp_reg[AW-1:0]];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointers; clear drops any staged words
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else if (clear_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_reg + (AW+1)'(push);
            rp_reg <= rp_reg + (AW+1)'(pop);
        end
    end

    // storage has no reset, it is data only
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wp_reg[AW-1:0]] <= in_data_i;
        end
    end
endmodule : dcf_stage_fifo

// ----------------------------------------------------------------
// top: memory, flags, retransmit, offset registers
// ----------------------------------------------------------------
module dcf_top #(
    parameter int DATA_W = `DCF_DATA_W,
    parameter int DEPTH = `DCF_DEPTH,
    parameter int OFF_W = $clog2(DEPTH)
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic master_reset_strobe_i,
    input wire logic partial_reset_strobe_i,
    input wire logic fall_through_mode_i,
    input wire logic retransmit_latency_select_i,
    input wire logic flag_timing_select_i,
    input wire logic offset_load_select_i,
    input wire logic write_en_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic read_en_i,
    input wire logic retransmit_request_i,
    output logic [DATA_W-1:0] data_o,
    output logic full_flag_n_o,
    output logic empty_flag_n_o,
    output logic input_ready_n_o,
    output logic output_ready_n_o,
    output logic almost_full_flag_n_o,
    output logic almost_empty_flag_n_o,
    output logic half_full_flag_n_o,
    output dcf_pkg::dcf_cfg_t cfg_o
);
    import dcf_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam int IW = $clog2(DEPTH);
    localparam int SW = $clog2(`DCF_STG_DEPTH);
    localparam int CW = IW + 2;                 // level width
    localparam logic [3:0] SETUP_CYC = 4'(`DCF_RT_SETUP_CYC);

    logic [DATA_W-1:0] mem [DEPTH];    // main storage array
    dcf_cfg_t cfg_reg;                 // latched mode selects
    dcf_rt_state_t rt_reg;             // retransmit sequencer
    logic [3:0] rt_cnt_reg;            // setup cycles left
    logic [IW:0] wp_reg;               // memory write pointer
    logic [IW:0] rp_reg;               // memory read pointer
    logic ov_reg;                      // fall-through output stage full
    logic [DATA_W-1:0] dout_reg;       // output register
    logic [OFF_W-1:0] pae_off_reg;     // almost-empty offset
    logic [OFF_W-1:0] paf_off_reg;     // almost-full offset
    logic ld_sel_reg;                  // next offset to load
    logic rd_sel_reg;                  // next offset to read back
    logic ff_n_reg;
    logic ef_n_reg;
    logic pae_n_reg;
    logic paf_n_reg;
    logic hf_n_reg;

    // staging buffer link
    logic stg_in_ready;
    logic stg_valid;
    logic [DATA_W-1:0] stg_data;
    logic [SW:0] stg_cnt;

    // ------------------------------------------------------------
    // level and decode
    // ------------------------------------------------------------
    // pointer difference; no wrap between resets per writer limit
    function automatic logic [CW-1:0] diff(input logic [IW:0] a,
                                           input logic [IW:0] b);
        diff = CW'(a - b);
    endfunction : diff

    wire clr = master_reset_strobe_i | partial_reset_strobe_i;
    wire in_setup = (rt_reg == DCF_RT_SETUP);
    wire [CW-1:0] mem_lvl = diff(wp_reg, rp_reg);
    // output stage counts as one extra word in fall-through
    wire [CW-1:0] cap = CW'(DEPTH) + CW'(cfg_reg.fall_through_mode);
    wire [CW-1:0] lvl = mem_lvl + CW'(ov_reg & cfg_reg.fall_through_mode);
    wire [CW-1:0] acc = lvl + CW'(stg_cnt);
    wire full_now = (acc >= cap);
    wire mem_room = (mem_lvl < CW'(DEPTH));
    wire mem_has = (mem_lvl != '0);
    // staging ready and full both stall the writer
    wire wr_ok = write_en_i & ~offset_load_select_i & ~full_now
                 & stg_in_ready & ~clr;
    wire drain = stg_valid & mem_room & ~clr;
    wire ld_wr = write_en_i & offset_load_select_i & ~clr;
    wire ld_rd = read_en_i & offset_load_select_i & ~clr;
    wire rd_req = read_en_i & ~offset_load_select_i & ~in_setup & ~clr;
    wire rt_go = retransmit_request_i & ~in_setup & ~clr;
    wire rt_zero = rt_go & cfg_reg.zero_lat;
    // standard read pops memory into the output register
    wire std_rd = ~cfg_reg.fall_through_mode & rd_req & mem_has & ~rt_go;
    // fall-through stage refills when empty or being read
    wire ft_take = cfg_reg.fall_through_mode & ov_reg & rd_req & ~rt_go;
    wire ft_fill = cfg_reg.fall_through_mode & mem_has & ~rt_go
                   & (~ov_reg | ft_take);
    wire mem_rd = std_rd | ft_fill;
    wire any_rd = std_rd | ft_take;
    wire setup_done = in_setup & (rt_cnt_reg == 4'h1);
    // almost conditions against the programmable offsets
    wire pae_cond = (lvl <= CW'(pae_off_reg));
    wire paf_cond = (acc >= cap - CW'(paf_off_reg));
    wire hf_cond = (acc > (cap >> 1));

    // ------------------------------------------------------------
    // staging buffer
    // ------------------------------------------------------------
    dcf_stage_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(`DCF_STG_DEPTH)
    ) u_stage (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .clear_i(clr),
        .in_valid_i(wr_ok),
        .in_ready_o(stg_in_ready),
        .in_data_i(data_i),
        .out_valid_o(stg_valid),
        .out_ready_i(mem_room),
        .out_data_o(stg_data),
        .count_o(stg_cnt)
    );

    // ------------------------------------------------------------
    // mode latch
    // ------------------------------------------------------------
    // selects caught by a clocked process, never by rst_i
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= '0;
        end else if (master_reset_strobe_i) begin
            cfg_reg.fall_through_mode <= fall_through_mode_i;
            cfg_reg.zero_lat <= ~retransmit_latency_select_i;
            cfg_reg.sync_flg <= flag_timing_select_i;
        end
    end

    // ------------------------------------------------------------
    // memory write
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (drain) begin
            mem[wp_reg[IW-1:0]] <= stg_data;
        end
    end

    // ------------------------------------------------------------
    // pointers and retransmit sequencer
    // ------------------------------------------------------------
    // retransmit rewinds the read pointer to location zero, or to one when word zero goes straight to the output
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            rt_reg <= DCF_RT_IDLE;
            rt_cnt_reg <= '0;
        end else if (clr) begin
            wp_reg <= '0;
            rp_reg <= '0;
            rt_reg <= DCF_RT_IDLE;
            rt_cnt_reg <= '0;
        end else begin
            wp_reg <= wp_reg + (IW+1)'(drain);
            unique case (rt_reg)
                DCF_RT_IDLE: begin
                    if (rt_zero) begin
                        // first word already taken into output
                        rp_reg <= (IW+1)'(1);
                    end else if (rt_go) begin
                        rp_reg <= '0;
                        rt_reg <= DCF_RT_SETUP;
                        rt_cnt_reg <= SETUP_CYC;
                    end else begin
                        rp_reg <= rp_reg + (IW+1)'(mem_rd);
                    end
                end
                DCF_RT_SETUP: begin
                    rt_cnt_reg <= rt_cnt_reg - 4'h1;
                    if (setup_done) begin
                        rt_reg <= DCF_RT_IDLE;
                        // fall-through shows location zero at end
                        rp_reg <= (IW+1)'(cfg_reg.fall_through_mode);
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // output register and fall-through stage
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_reg <= '0;
            ov_reg <= 1'b0;
        end else if (clr) begin
            dout_reg <= '0;
            ov_reg <= 1'b0;
        end else if (ld_rd) begin
            // offset read-back, alternating empty then full
            dout_reg <= DATA_W'(rd_sel_reg ? paf_off_reg
                                            : pae_off_reg);
        end else if (rt_zero) begin
            // word zero lands on the requesting edge
            dout_reg <= mem[0];
            ov_reg <= cfg_reg.fall_through_mode;
        end else if (rt_go) begin
            ov_reg <= 1'b0;
        end else if (setup_done & cfg_reg.fall_through_mode) begin
            dout_reg <= mem[0];
            ov_reg <= 1'b1;
        end else if (mem_rd) begin
            // fill: empty stage loads one edge after mem level rises
            dout_reg <= mem[rp_reg[IW-1:0]];
            ov_reg <= cfg_reg.fall_through_mode;
        end else if (ft_take) begin
            ov_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // offset registers
    // ------------------------------------------------------------
    // parallel load: first write empty offset, second full offset
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pae_off_reg <= OFF_W'(`DCF_OFFSET_DEF);
            paf_off_reg <= OFF_W'(`DCF_OFFSET_DEF);
            ld_sel_reg <= 1'b0;
            rd_sel_reg <= 1'b0;
        end else if (master_reset_strobe_i) begin
            pae_off_reg <= OFF_W'(`DCF_OFFSET_DEF);
            paf_off_reg <= OFF_W'(`DCF_OFFSET_DEF);
            ld_sel_reg <= 1'b0;
            rd_sel_reg <= 1'b0;
        end else if (partial_reset_strobe_i) begin
            // partial reset keeps offsets, restarts sequence
            ld_sel_reg <= 1'b0;
            rd_sel_reg <= 1'b0;
        end else begin
            if (ld_wr & ~ld_sel_reg) begin
                pae_off_reg <= data_i[OFF_W-1:0];
            end
            if (ld_wr & ld_sel_reg) begin
                paf_off_reg <= data_i[OFF_W-1:0];
            end
            ld_sel_reg <= ld_sel_reg ^ ld_wr;
            rd_sel_reg <= rd_sel_reg ^ ld_rd;
        end
    end

    // ------------------------------------------------------------
    // status flags, all active low
    // ------------------------------------------------------------
    // full and ready come from the level one edge after the change
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ff_n_reg <= 1'b1;
            ef_n_reg <= 1'b0;
            hf_n_reg <= 1'b1;
        end else if (clr) begin
            ff_n_reg <= 1'b1;
            ef_n_reg <= 1'b0;
            hf_n_reg <= 1'b1;
        end else begin
            ff_n_reg <= ~full_now;
            hf_n_reg <= ~hf_cond;
            if (rt_zero) begin
                // updated on the retransmit edge even when empty
                ef_n_reg <= 1'b1;
            end else if (rt_go | in_setup) begin
                // held low through setup, high marks the end;
                // fall-through shows ready with word zero at once
                ef_n_reg <= setup_done;
            end else if (cfg_reg.fall_through_mode) begin
                ef_n_reg <= ov_reg;
            end else begin
                ef_n_reg <= mem_has;
            end
        end
    end

    // almost flags: sync mode follows level, async set/free by port
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pae_n_reg <= 1'b0;
            paf_n_reg <= 1'b1;
        end else if (clr) begin
            pae_n_reg <= 1'b0;
            paf_n_reg <= 1'b1;
        end else if (cfg_reg.sync_flg) begin
            pae_n_reg <= ~pae_cond;
            paf_n_reg <= ~paf_cond;
        end else begin
            // low only after reads or retransmit, high only after writes
            if (pae_cond & (any_rd | rt_go)) begin
                pae_n_reg <= 1'b0;
            end else if (~pae_cond & drain) begin
                pae_n_reg <= 1'b1;
            end
            // low only after writes, high only after reads or retransmit
            if (paf_cond & wr_ok) begin
                paf_n_reg <= 1'b0;
            end else if (~paf_cond & (any_rd | rt_go)) begin
                paf_n_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs from flip-flops, the ready pair through an inverter
    // ------------------------------------------------------------
    // the unused mode's pair mirrors the active one
    assign data_o = dout_reg;
    assign full_flag_n_o = ff_n_reg;
    assign input_ready_n_o = ~ff_n_reg;
    assign empty_flag_n_o = ef_n_reg;
    assign output_ready_n_o = ~ef_n_reg;
    assign almost_full_flag_n_o = paf_n_reg;
    assign almost_empty_flag_n_o = pae_n_reg;
    assign half_full_flag_n_o = hf_n_reg;
    assign cfg_o = cfg_reg;
endmodule : dcf_top

// ==== verification/dcf_reader_model.sv ====
// reader-side partner model that pulls shown words off the fifo output
`timescale 1ns/1ps
module dcf_reader_model #(
    parameter int W = 36
) (
    input wire logic core_clk_i,
    input wire logic enable_i,
    input wire logic slow_i,
    input wire logic ft_i,
    input wire logic shown_i,
    input wire logic line_read_i,
    input wire logic off_sel_i,
    input wire logic [W-1:0] data_i,
    output logic read_en_o,
    output logic got_o,
    output logic [W-1:0] word_o
);
    logic gap_reg = 1'b0;  // idle cycle so the flags catch up after a read
    logic took_reg = 1'b0; // a data read was taken at the last edge
    logic [W-1:0] head_reg; // word shown before that edge
    initial begin
        read_en_o = 1'b0;
        got_o = 1'b0;
    end
    // read only a shown word; setup keeps the word hidden
    always @(negedge core_clk_i) begin
        read_en_o <= enable_i && shown_i && !gap_reg && !read_en_o;
        gap_reg <= read_en_o || (gap_reg && slow_i);
        got_o <= took_reg;
        word_o <= ft_i ? head_reg : data_i;
    end
    // fall-through hands over the shown word, standard the loaded one
    always @(posedge core_clk_i) begin
        took_reg <= line_read_i && !off_sel_i;
        head_reg <= data_i;
    end
endmodule : dcf_reader_model

// ==== verification/dcf_top_props.sv ====
// concurrent checks on the ports of the flag and retransmit fifo
`timescale 1ns/1ps
module dcf_top_props (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic master_reset_strobe_i,
    input wire logic partial_reset_strobe_i,
    input wire logic offset_load_select_i,
    input wire logic write_en_i,
    input wire logic read_en_i,
    input wire logic retransmit_request_i,
    input wire logic full_flag_n_o,
    input wire logic empty_flag_n_o,
    input wire logic almost_full_flag_n_o,
    input wire logic almost_empty_flag_n_o,
    input wire logic half_full_flag_n_o,
    input wire dcf_pkg::dcf_cfg_t cfg_o
);
    import dcf_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    wire calm = !master_reset_strobe_i && !partial_reset_strobe_i;
    wire data_wr = write_en_i && !offset_load_select_i && calm;
    wire data_rd = read_en_i && !offset_load_select_i && calm;
    // anything allowed to lower the level or clear the flags
    wire drop = read_en_i || retransmit_request_i || !calm;
    property p_full_release;
        !full_flag_n_o && data_rd && !write_en_i && !retransmit_request_i
            |-> ##2 full_flag_n_o;
    endproperty
    a_full_release: assert property (p_full_release)
        else $error("full kept after a freeing read");
    property p_first_std;
        !cfg_o.fall_through_mode && !empty_flag_n_o && data_wr && !retransmit_request_i
            |-> ##3 empty_flag_n_o;
    endproperty
    a_first_std: assert property (p_first_std)
        else $error("standard first word late");
    property p_first_ft;
        cfg_o.fall_through_mode && !empty_flag_n_o && data_wr && !retransmit_request_i
            ##1 (!read_en_i)[*3] |=> empty_flag_n_o;
    endproperty
    a_first_ft: assert property (p_first_ft)
        else $error("fall-through first word late");
    property p_rt_normal;
        !cfg_o.zero_lat && retransmit_request_i && calm
            |=> (!empty_flag_n_o)[*3] ##1 empty_flag_n_o;
    endproperty
    a_rt_normal: assert property (p_rt_normal)
        else $error("normal retransmit setup length wrong");
    property p_rt_zero;
        cfg_o.zero_lat && retransmit_request_i && calm |=> empty_flag_n_o;
    endproperty
    a_rt_zero: assert property (p_rt_zero)
        else $error("zero retransmit did not show a word");
    property p_paf_async;
        !cfg_o.sync_flg && $fell(almost_full_flag_n_o)
            |-> $past(write_en_i) || $past(write_en_i, 2);
    endproperty
    a_paf_async: assert property (p_paf_async)
        else $error("almost full set without a write");
    property p_pae_async;
        !cfg_o.sync_flg && $fell(almost_empty_flag_n_o)
            |-> $past(drop) || $past(drop, 2);
    endproperty
    a_pae_async: assert property (p_pae_async)
        else $error("almost empty set without a read");
    property p_half_clear;
        $rose(half_full_flag_n_o) |-> $past(drop) || $past(drop, 2);
    endproperty
    a_half_clear: assert property (p_half_clear)
        else $error("half full cleared without a read");
    c_full_read: cover property (!full_flag_n_o && data_rd);
    c_rt_normal: cover property (!cfg_o.zero_lat && retransmit_request_i);
    c_rt_zero: cover property (cfg_o.zero_lat && retransmit_request_i);
endmodule : dcf_top_props

bind dcf_top dcf_top_props u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .master_reset_strobe_i(master_reset_strobe_i),
    .partial_reset_strobe_i(partial_reset_strobe_i),
    .offset_load_select_i(offset_load_select_i),
    .write_en_i(write_en_i), .read_en_i(read_en_i),
    .retransmit_request_i(retransmit_request_i),
    .full_flag_n_o(full_flag_n_o), .empty_flag_n_o(empty_flag_n_o),
    .almost_full_flag_n_o(almost_full_flag_n_o),
    .almost_empty_flag_n_o(almost_empty_flag_n_o),
    .half_full_flag_n_o(half_full_flag_n_o), .cfg_o(cfg_o)
);

// ==== verification/dcf_top_tb.sv ====
// self-checking testbench of the flag and retransmit fifo
`timescale 1ns/1ps
`include "dcf_defines.svh"
module dcf_top_tb;
    import dcf_pkg::*;
    localparam int DEPTH = 16;         // short depth keeps fills brief
    localparam int W = `DCF_DATA_W;
    localparam int OW = $clog2(DEPTH); // offset width at this depth
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mstb = 1'b0;
    logic pstb = 1'b0;
    logic ft_sel = 1'b0;
    logic lat_sel = 1'b1;
    logic tim_sel = 1'b0;
    logic off_sel = 1'b0;
    logic wen = 1'b0;
    logic [W-1:0] din = '0;
    logic tb_ren = 1'b0;
    logic retx = 1'b0;
    logic model_en = 1'b0; // partner may read
    logic slow = 1'b0;     // partner stalls
    logic model_ren, got, full_n, empty_n, inrdy_n, outrdy_n;
    logic afull_n, aempty_n, half_n;
    logic [W-1:0] word, dout;
    dcf_cfg_t cfg;
    int num_errors = 0;
    int n_tests = 0;
    int cap = DEPTH;       // words the fifo takes in this mode
    logic [W-1:0] q[$];    // model: words still to be read
    logic [W-1:0] sent[$]; // words since the last strobe
    wire ren = tb_ren | model_ren;
    wire shown = ft_sel ? !outrdy_n : empty_n;
    always #20 clk = ~clk;
    always @(negedge clk) slow <= 1'($urandom % 2);
    dcf_top #(.DEPTH(DEPTH)) dut (
        .core_clk_i(clk), .rst_i(rst), .master_reset_strobe_i(mstb),
        .partial_reset_strobe_i(pstb), .fall_through_mode_i(ft_sel),
        .retransmit_latency_select_i(lat_sel),
        .flag_timing_select_i(tim_sel), .offset_load_select_i(off_sel),
        .write_en_i(wen), .data_i(din), .read_en_i(ren),
        .retransmit_request_i(retx), .data_o(dout), .full_flag_n_o(full_n),
        .empty_flag_n_o(empty_n), .input_ready_n_o(inrdy_n),
        .output_ready_n_o(outrdy_n), .almost_full_flag_n_o(afull_n),
        .almost_empty_flag_n_o(aempty_n), .half_full_flag_n_o(half_n),
        .cfg_o(cfg));
    dcf_reader_model #(.W(W)) u_reader (
        .core_clk_i(clk), .enable_i(model_en), .slow_i(slow),
        .ft_i(ft_sel), .shown_i(shown), .line_read_i(ren),
        .off_sel_i(off_sel), .data_i(dout), .read_en_o(model_ren),
        .got_o(got), .word_o(word));
    task automatic check_word(input logic [W-1:0] a, input logic [W-1:0] e,
        input string what);
        n_tests++;
        if (a !== e) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, a, e);
        end
    endtask : check_word
    task automatic check_flag(input logic a, input logic e, input string what);
        check_word(W'(a), W'(e), what);
    endtask : check_flag
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    function automatic logic [W-1:0] rnd();
        return W'({$urandom, $urandom});
    endfunction : rnd
    // every word the partner takes is compared with the model
    always @(posedge clk) begin
        if (got) begin
            check_word(word, q.size() ? q[0] : 'x, "read word");
            if (q.size()) void'(q.pop_front());
        end
    end
    // one write held for one edge; refused ones never reach the model
    task automatic put(input logic [W-1:0] v, input logic ofs);
        off_sel = ofs;
        wen = 1'b1;
        din = v;
        @(negedge clk);
        if (!ofs && q.size() < cap) begin
            q.push_back(v);
            sent.push_back(v);
        end
    endtask : put
    task automatic idle(input int n);
        wen = 1'b0;
        tb_ren = 1'b0;
        off_sel = 1'b0;
        repeat (n) @(negedge clk);
    endtask : idle
    // let the partner read until the model runs dry, bounded
    task automatic drain();
        int k;
        model_en = 1'b1;
        for (k = 0; k < 300 && q.size() > 0; k++) @(negedge clk);
        model_en = 1'b0;
        check_flag(q.size() == 0, 1'b1, "drain finished");
        idle(4);
    endtask : drain
    task automatic run_mode(input logic f, input logic r, input logic p);
        int i, n, m;
        cap = DEPTH + 32'(f); // extra output stage
        ft_sel = f;
        lat_sel = r;
        tim_sel = p;
        mstb = 1'b1;
        @(negedge clk);
        mstb = 1'b0;
        q.delete();
        sent.delete();
        @(negedge clk);
        check_word(W'(cfg), W'({f, !r, p}), "modes");
        n = 1 + $urandom % 3;
        m = 1 + $urandom % 3;
        put(W'(n), 1'b1);
        put(W'(m), 1'b1);
        idle(1);
        for (i = 0; i < 2; i++) begin
            off_sel = 1'b1;
            tb_ren = 1'b1;
            @(negedge clk);
            check_word(W'(dout[OW-1:0]), W'(i ? m : n), "offset");
        end
        idle(1);
        for (i = 0; i < cap - 1; i++) put(rnd(), 1'b0);
        idle(3);
        check_flag(full_n, 1'b1, "one short of full");
        check_flag(aempty_n, 1'b1, "almost empty off");
        put(rnd(), 1'b0);
        put(rnd(), 1'b0);
        idle(3);
        check_flag(full_n, 1'b0, "full");
        check_flag(afull_n, 1'b0, "almost full");
        check_flag(half_n, 1'b0, "half full");
        tb_ren = 1'b1;
        @(negedge clk);
        idle(1);
        check_flag(full_n, 1'b1, "full released");
        check_flag(inrdy_n, 1'b0, "input ready back");
        drain();
        check_flag(empty_n, 1'b0, "empty after drain");
        check_flag(aempty_n, 1'b0, "almost empty");
        check_flag(afull_n, 1'b1, "almost full off");
        check_flag(half_n, 1'b1, "half full off");
        check_flag(outrdy_n, 1'b1, "no word shown");
        pstb = 1'b1;
        @(negedge clk);
        pstb = 1'b0;
        q.delete();
        sent.delete();
        for (i = 0; i < 5; i++) put(rnd(), 1'b0);
        idle(1);
        drain(); // all five read, fifo empty at retransmit
        q = sent;
        retx = 1'b1;
        @(negedge clk);
        retx = 1'b0;
        if (!r) check_word(dout, sent[0], "zero retransmit");
        if (!r && !f) void'(q.pop_front()); // word 0 counts as read
        drain(); // replay from the first word
    endtask : run_mode
    initial begin : main
        int k;
        void'($urandom(32'h08F1));
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        // every timing, latency and flag-style select is set both ways
        for (k = 0; k < 4; k++) run_mode(k[0], k[1], k[0] ^ k[1]);
        tally_and_finish();
    end
    // about nine times the expected run of some 650 cycles
    initial begin : watchdog
        #(40 * 6000);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : dcf_top_tb
